// ---- acs_pkg.sv ----
package acs_pkg;

   // ----------------------------------------------------------------
   // Widths and control word layout
   // ----------------------------------------------------------------
   localparam int          ACS_DATA_W    = 12;
   localparam int          ACS_CH_W      = 2;
   localparam int          ACS_BYTE_W    = 8;
   localparam int          ACS_HIGH_W    = ACS_DATA_W - ACS_BYTE_W;
   localparam int          CR_PM_LO      = 0;
   localparam int          CR_PM_HI      = 1;
   localparam int          CR_REF        = 2;
   localparam int          CR_SEQ_LO     = 3;
   localparam int          CR_SEQ_HI     = 4;
   localparam int          CR_ADDR_LO    = 5;
   localparam int          CR_ADDR_HI    = 6;
   localparam logic [11:0] CR_RESET      = 12'h000;
   localparam logic [1:0]  SEQ_CONSEC    = 2'h3;
   localparam logic [1:0]  PM_SHUTDOWN   = 2'h1;
   localparam logic [1:0]  PM_STANDBY    = 2'h2;
   localparam logic [1:0]  PM_FULL_OFF   = 2'h3;
   localparam int          HB_ZERO_BIT   = 4;
   localparam int          HB_CHAN_LO    = 5;

   // ----------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------
   localparam logic [3:0]  TRACK_EDGE    = 4'hD;
   localparam logic [3:0]  CONV_EDGES    = 4'hE;
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          ACQ_TIME_NS   = 135;
   localparam int          ACQ_CYCLES    = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  CCLK_HALF     = 2'h1;
   localparam logic [1:0]  WR_CYCLES     = 2'h1;
   localparam logic [1:0]  RD_CYCLES     = 2'h2;

   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PWR_NORMAL   = 2'b00,
      PWR_SHUTDOWN = 2'b01,
      PWR_STANDBY  = 2'b10,
      PWR_FULL_OFF = 2'b11
   } acs_power_e;

endpackage

// ---- acs_if.sv ----
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Parallel port between converter and host
// --------------------------------------------------------------------
interface acs_if;
   import acs_pkg::*;
   logic                  startStrobeN;
   logic                  conversionClockIn;
   logic                  busy;
   logic                  csN;
   logic                  rdN;
   logic                  wrN;
   logic                  wordByteSel;
   logic                  hben;
   logic [ACS_DATA_W-1:0] dataDev;
   logic                  dataDevOe;
   logic [ACS_DATA_W-1:0] dataHost;
   logic                  dataHostOe;

   modport dev
   (
      input  startStrobeN, conversionClockIn, csN, rdN, wrN, wordByteSel, hben, dataHost, dataHostOe,
      output busy, dataDev, dataDevOe
   );
   modport host
   (
      output startStrobeN, conversionClockIn, csN, rdN, wrN, wordByteSel, hben, dataHost, dataHostOe,
      input  busy, dataDev, dataDevOe
   );
endinterface

// ---- acs_device.sv ----
`timescale 1ns/1ps
module acs_device
(
   input  wire logic                           clk,
   input  wire logic                           reset,
   acs_if.dev                                  port,
   input  wire logic [acs_pkg::ACS_DATA_W-1:0] sarResult,
   output      logic                           trackMode,
   output      logic                           refInternal,
   output      acs_pkg::acs_power_e            powerState,
   output      logic [acs_pkg::ACS_CH_W-1:0]   convChannel
);
   import acs_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                  clkPrev,    next_clkPrev;
   logic                  startPrev,  next_startPrev;
   logic                  wrPrev,     next_wrPrev;
   logic                  csPrev,     next_csPrev;
   logic                  busy,       next_busy;
   logic [3:0]            edgeCnt,    next_edgeCnt;
   logic                  next_trackMode;
   acs_power_e            next_powerState;
   logic [ACS_DATA_W-1:0] ctrl,       next_ctrl;
   logic [ACS_BYTE_W-1:0] lowStage,   next_lowStage;
   logic [ACS_CH_W-1:0]   seqChan,    next_seqChan;
   logic [ACS_CH_W-1:0]   next_convChannel;
   logic [ACS_CH_W-1:0]   resChan,    next_resChan;
   logic [ACS_DATA_W-1:0] result,     next_result;
   logic [ACS_DATA_W-1:0] dataOut,    next_dataOut;
   logic                  dataOe,     next_dataOe;

   logic                  clkRise;
   logic                  startFall;
   logic                  startRise;
   logic                  wrCommit;
   logic [ACS_DATA_W-1:0] wrWord;
   logic [1:0]            seqMode;
   logic [1:0]            pmMode;
   logic [ACS_CH_W-1:0]   lastChan;

   assign port.busy      = busy;
   assign port.dataDev   = dataOut;
   assign port.dataDevOe = dataOe;
   assign refInternal    = ctrl[CR_REF];

   // Power state that an automatic mode falls into after a conversion.
   function automatic acs_power_e idle_power(input logic [1:0] pm);
      case (pm)
         PM_SHUTDOWN: idle_power = PWR_SHUTDOWN;
         PM_STANDBY:  idle_power = PWR_STANDBY;
         PM_FULL_OFF: idle_power = PWR_FULL_OFF;
         default:     idle_power = PWR_NORMAL;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin edge detection
   // ----------------------------------------------------------------
   // The pins are synchronous to clk, so one history flop per pin is enough.
   always_comb
   begin
      next_clkPrev   = port.conversionClockIn;
      next_startPrev = port.startStrobeN;
      next_wrPrev    = port.wrN;
      next_csPrev    = port.csN;
      clkRise        = port.conversionClockIn & ~clkPrev;
      startFall      = ~port.startStrobeN & startPrev;
      startRise      = port.startStrobeN & ~startPrev;
      // Data is latched on the write strobe rising edge while selected.
      wrCommit       = port.wrN & ~wrPrev & ~csPrev;
      seqMode        = {ctrl[CR_SEQ_HI], ctrl[CR_SEQ_LO]};
      pmMode         = {ctrl[CR_PM_HI], ctrl[CR_PM_LO]};
      lastChan       = ctrl[CR_ADDR_HI:CR_ADDR_LO];
   end

   // History follows the pins even during reset, so release never shows a false edge
   // whatever level the host parks its strobes at.
   always_ff @(posedge clk)
   begin
      clkPrev   <= next_clkPrev;
      startPrev <= next_startPrev;
      wrPrev    <= next_wrPrev;
      csPrev    <= next_csPrev;
   end

   // ----------------------------------------------------------------
   // Control register writes
   // ----------------------------------------------------------------
   // In byte mode the low byte is staged and the high write commits the word,
   // so a half-written word never steers the sequencer.
   always_comb
   begin
      next_ctrl     = ctrl;
      next_lowStage = lowStage;
      wrWord        = {port.dataHost[ACS_HIGH_W-1:0], lowStage};
      if (wrCommit)
      begin
         if (port.wordByteSel)
            next_ctrl = port.dataHost;
         else if (port.hben)
            next_ctrl = wrWord;
         else
            next_lowStage = port.dataHost[ACS_BYTE_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl     <= CR_RESET;
         lowStage <= '0;
      end
      else
      begin
         ctrl     <= next_ctrl;
         lowStage <= next_lowStage;
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencing, track-and-hold and power
   // ----------------------------------------------------------------
   always_comb
   begin
      next_busy        = busy;
      next_edgeCnt     = edgeCnt;
      next_trackMode   = trackMode;
      next_powerState  = powerState;
      next_seqChan     = seqChan;
      next_convChannel = convChannel;
      next_resChan     = resChan;
      next_result      = result;
      if (startFall && !busy)
      begin
         next_busy      = 1'b1;
         next_edgeCnt   = '0;
         next_trackMode = 1'b0;
         if (seqMode == SEQ_CONSEC)
            next_convChannel = seqChan;
         else
            next_convChannel = lastChan;
      end
      else if (busy && startRise)
      begin
         // The strobe came back before the conversion finished.
         next_busy      = 1'b0;
         next_trackMode = 1'b1;
      end
      else if (busy && clkRise)
      begin
         next_edgeCnt = edgeCnt + 4'h1;
         if (next_edgeCnt == TRACK_EDGE)
            next_trackMode = 1'b1;
         if (next_edgeCnt == CONV_EDGES)
         begin
            next_busy       = 1'b0;
            next_result     = sarResult;
            next_resChan    = convChannel;
            next_powerState = idle_power(pmMode);
            if (seqMode == SEQ_CONSEC)
            begin
               if (convChannel == lastChan)
                  next_seqChan = '0;
               else
                  next_seqChan = convChannel + 2'h1;
            end
         end
      end
      else if (startRise)
      begin
         next_trackMode  = 1'b1;
         next_powerState = PWR_NORMAL;
      end
      // A control write restarts the sequence; full-off mode bits force full shutdown whenever no conversion is busy.
      if (wrCommit && next_ctrl != ctrl)
         next_seqChan = '0;
      else if (wrCommit)
         next_seqChan = '0;
      if ({next_ctrl[CR_PM_HI], next_ctrl[CR_PM_LO]} == PM_FULL_OFF && !next_busy)
         next_powerState = PWR_FULL_OFF;
   end

   // Hold after reset: the track switch waits for the first strobe rise.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         busy        <= 1'b0;
         edgeCnt     <= '0;
         trackMode   <= 1'b0;
         powerState  <= PWR_NORMAL;
         seqChan     <= '0;
         convChannel <= '0;
         resChan     <= '0;
         result      <= '0;
      end
      else
      begin
         busy        <= next_busy;
         edgeCnt     <= next_edgeCnt;
         trackMode   <= next_trackMode;
         powerState  <= next_powerState;
         seqChan     <= next_seqChan;
         convChannel <= next_convChannel;
         resChan     <= next_resChan;
         result      <= next_result;
      end
   end

   // ----------------------------------------------------------------
   // Result read port
   // ----------------------------------------------------------------
   // Data appears one cycle after both strobes are low and drops one cycle
   // after either rises; the host must allow for that lag.
   always_comb
   begin
      next_dataOe  = ~port.csN & ~port.rdN;
      next_dataOut = '0;
      if (next_dataOe)
      begin
         if (port.wordByteSel)
            next_dataOut = result;
         else if (port.hben)
         begin
            next_dataOut[ACS_HIGH_W-1:0]              = result[ACS_DATA_W-1:ACS_BYTE_W];
            next_dataOut[HB_ZERO_BIT]                 = 1'b0;
            next_dataOut[HB_CHAN_LO+ACS_CH_W-1:HB_CHAN_LO] = resChan;
         end
         else
            next_dataOut[ACS_BYTE_W-1:0] = result[ACS_BYTE_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         dataOe  <= 1'b0;
         dataOut <= '0;
      end
      else
      begin
         dataOe  <= next_dataOe;
         dataOut <= next_dataOut;
      end
   end

endmodule

// ---- acs_host.sv ----
`timescale 1ns/1ps
module acs_host
(
   input  wire logic                           clk,
   input  wire logic                           reset,
   acs_if.host                                 port,
   input  wire logic                           cmdWrite,
   input  wire logic [acs_pkg::ACS_DATA_W-1:0] cmdWord,
   input  wire logic                           cmdConvert,
   output      logic                           ready,
   output      logic [acs_pkg::ACS_DATA_W-1:0] resultData,
   output      logic                           resultValid
);
   import acs_pkg::*;

   typedef enum logic [2:0]
   {
      H_IDLE  = 3'b000,
      H_WRITE = 3'b001,
      H_WREL  = 3'b010,
      H_ACQ   = 3'b011,
      H_CONV  = 3'b100,
      H_READ  = 3'b101
   } acs_hstate_e;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   acs_hstate_e           state,    next_state;
   logic [1:0]            divCnt,   next_divCnt;
   logic                  cclk,     next_cclk;
   logic                  cclkRise;
   logic [5:0]            waitCnt,  next_waitCnt;
   logic [3:0]            edges,    next_edges;
   logic                  startN,   next_startN;
   logic                  csN,      next_csN;
   logic                  rdN,      next_rdN;
   logic                  wrN,      next_wrN;
   logic [ACS_DATA_W-1:0] wdata,    next_wdata;
   logic                  woe,      next_woe;
   logic                  next_ready;
   logic [ACS_DATA_W-1:0] next_resultData;
   logic                  next_resultValid;

   assign port.startStrobeN      = startN;
   assign port.conversionClockIn = cclk;
   assign port.csN               = csN;
   assign port.rdN               = rdN;
   assign port.wrN               = wrN;
   assign port.wordByteSel       = 1'b1;
   assign port.hben              = 1'b0;
   assign port.dataHost          = wdata;
   assign port.dataHostOe        = woe;

   // ----------------------------------------------------------------
   // Conversion clock divider and sequencing
   // ----------------------------------------------------------------
   // The conversion clock runs free so the converter always sees its edges.
   always_comb
   begin
      next_divCnt      = divCnt + 2'h1;
      next_cclk        = cclk;
      cclkRise         = 1'b0;
      if (divCnt == CCLK_HALF)
      begin
         next_divCnt = '0;
         next_cclk   = ~cclk;
         cclkRise    = ~cclk;
      end
      next_state       = state;
      next_waitCnt     = waitCnt;
      next_edges       = edges;
      next_startN      = startN;
      next_csN         = 1'b1;
      next_rdN         = 1'b1;
      next_wrN         = 1'b1;
      next_wdata       = wdata;
      next_woe         = 1'b0;
      next_resultData  = resultData;
      next_resultValid = 1'b0;
      case (state)
         H_IDLE:
         begin
            next_waitCnt = '0;
            if (cmdWrite)
            begin
               next_state = H_WRITE;
               next_wdata = cmdWord;
               next_woe   = 1'b1;
               next_csN   = 1'b0;
               next_wrN   = 1'b0;
            end
            else if (cmdConvert)
            begin
               next_state  = H_ACQ;
               next_startN = 1'b1;
            end
         end
         H_WRITE:
         begin
            next_woe     = 1'b1;
            next_csN     = 1'b0;
            next_wrN     = 1'b0;
            next_waitCnt = waitCnt + 6'h01;
            if (waitCnt[1:0] == WR_CYCLES)
               next_state = H_WREL;
         end
         H_WREL:
         begin
            next_woe   = 1'b1;                                       // Data held past the strobe rise.
            next_state = H_IDLE;
         end
         H_ACQ:
         begin
            next_waitCnt = waitCnt + 6'h01;
            if (waitCnt == 6'(ACQ_CYCLES - 1))
            begin
               next_state  = H_CONV;
               next_startN = 1'b0;
               next_edges  = '0;
            end
         end
         H_CONV:
         begin
            if (cclkRise && edges != CONV_EDGES)
               next_edges = edges + 4'h1;
            // Strobe stays low past the 14th edge; it rises on the next acquisition.
            if (edges == CONV_EDGES && !port.busy)
            begin
               next_state   = H_READ;
               next_waitCnt = '0;
               next_csN     = 1'b0;
               next_rdN     = 1'b0;
            end
         end
         H_READ:
         begin
            next_csN     = 1'b0;
            next_rdN     = 1'b0;
            next_waitCnt = waitCnt + 6'h01;
            if (waitCnt[1:0] == RD_CYCLES)
            begin
               next_csN         = 1'b1;
               next_rdN         = 1'b1;
               next_resultData  = port.dataDev;
               next_resultValid = 1'b1;
               next_state       = H_IDLE;
            end
         end
         default:
            next_state = H_IDLE;
      endcase
      next_ready = (next_state == H_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state       <= H_IDLE;
         divCnt      <= '0;
         cclk        <= 1'b0;
         waitCnt     <= '0;
         edges       <= '0;
         startN      <= 1'b0;
         csN         <= 1'b1;
         rdN         <= 1'b1;
         wrN         <= 1'b1;
         wdata       <= '0;
         woe         <= 1'b0;
         ready       <= 1'b0;
         resultData  <= '0;
         resultValid <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         divCnt      <= next_divCnt;
         cclk        <= next_cclk;
         waitCnt     <= next_waitCnt;
         edges       <= next_edges;
         startN      <= next_startN;
         csN         <= next_csN;
         rdN         <= next_rdN;
         wrN         <= next_wrN;
         wdata       <= next_wdata;
         woe         <= next_woe;
         ready       <= next_ready;
         resultData  <= next_resultData;
         resultValid <= next_resultValid;
      end
   end

endmodule

// ---- acs_monitor.sv ----
`timescale 1ns/1ps
module acs_monitor
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic startStrobeN,
   input wire logic conversionClockIn,
   input wire logic busy,
   input wire logic csN,
   input wire logic rdN,
   input wire logic dataDevOe
);
   logic       ccPrev;
   logic       next_ccPrev;
   logic [3:0] riseCnt;
   logic [3:0] next_riseCnt;

   // Counts conversion clock rises while busy, so the end of busy can be tied to the edge count.
   always_comb
   begin
      next_ccPrev  = reset ? 1'b0 : conversionClockIn;
      next_riseCnt = (busy && !reset) ? riseCnt + 4'(conversionClockIn & ~ccPrev) : 4'h0;
   end

   // Registers only; the reset mux lives in the next-value logic.
   always_ff @(posedge clk)
   begin
      ccPrev  <= next_ccPrev;
      riseCnt <= next_riseCnt;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // A fall of start seen while idle; busy is expected on the following edge.
   sequence s_startFall;
      $fell(startStrobeN) && !busy;
   endsequence
   sequence s_fallBefore;
      !$past(startStrobeN) && $past(startStrobeN, 2);
   endsequence

   a_busy_start: assert property (s_startFall |=> busy)
      else $error("busy missing after start fall");
   a_busy_cause: assert property ($rose(busy) |-> s_fallBefore)
      else $error("busy rose without a start fall");
   a_busy_hold: assert property (busy && !startStrobeN && riseCnt < TRACK_EDGE |=> busy)
      else $error("busy dropped early");
   a_busy_limit: assert property (busy |-> riseCnt < CONV_EDGES)
      else $error("busy outlived its edge count");
   a_busy_end: assert property ($fell(busy) |-> riseCnt == CONV_EDGES || $past(startStrobeN))
      else $error("busy fell at the wrong edge");
   a_abort_early: assert property (busy && startStrobeN |=> !busy)
      else $error("early start rise did not abort");
   a_read_drive: assert property (!csN && !rdN |=> dataDevOe)
      else $error("read data not driven");
   a_read_release: assert property (csN || rdN |=> !dataDevOe)
      else $error("read data driven while not selected");
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import acs_pkg::*;
   logic                  clk;
   logic                  reset;
   logic                  cmdWrite;
   logic                  cmdConvert;
   logic [ACS_DATA_W-1:0] cmdWord;
   logic [ACS_DATA_W-1:0] sarResult;
   logic                  ready;
   logic                  resultValid;
   logic                  trackMode;
   logic                  refInternal;
   logic [ACS_DATA_W-1:0] resultData;
   logic [ACS_CH_W-1:0]   convChannel;
   acs_power_e            powerState;
   int                    n_errors;
   int                    tests_run;
   int                    k;

   acs_if u_acs_if ();

   acs_device u_acs_device
   (
      .clk         (clk),
      .reset       (reset),
      .port        (u_acs_if),
      .sarResult   (sarResult),
      .trackMode   (trackMode),
      .refInternal (refInternal),
      .powerState  (powerState),
      .convChannel (convChannel)
   );

   acs_host u_acs_host
   (
      .clk         (clk),
      .reset       (reset),
      .port        (u_acs_if),
      .cmdWrite    (cmdWrite),
      .cmdWord     (cmdWord),
      .cmdConvert  (cmdConvert),
      .ready       (ready),
      .resultData  (resultData),
      .resultValid (resultValid)
   );

   acs_monitor u_acs_monitor
   (
      .clk               (clk),
      .reset             (reset),
      .startStrobeN      (u_acs_if.startStrobeN),
      .conversionClockIn (u_acs_if.conversionClockIn),
      .busy              (u_acs_if.busy),
      .csN               (u_acs_if.csN),
      .rdN               (u_acs_if.rdN),
      .dataDevOe         (u_acs_if.dataDevOe)
   );

   // Free-running 250 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // --------------------------------------------------------------
   // Checking and closing
   // --------------------------------------------------------------
   task automatic chk(input string what, input logic [11:0] want, input logic [11:0] got);
      tests_run++;
      if (got !== want)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, want, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // A wait that ran out is a mismatch and ends the run at once.
   task automatic give_up(input string what);
      n_errors++;
      $display("BAD %s expected high seen low", what);
      tally_and_finish();
   endtask

   // --------------------------------------------------------------
   // Host commands
   // --------------------------------------------------------------
   task automatic write_ctrl(input logic [1:0] pm, input logic rf, input logic [1:0] seq, input logic [1:0] ad);
      cmdWord  = {5'h00, ad, seq, rf, pm};
      cmdWrite = 1'b1;
      @(negedge clk);
      cmdWrite = 1'b0;
      repeat (2) @(negedge clk);
      for (k = 0; k < 50 && ready !== 1'b1; k++)
         @(negedge clk);
      if (ready !== 1'b1)
         give_up("ready");
      // The device commits the word on the edge after the write strobe rises.
      @(negedge clk);
      chk("refInternal", 12'(rf), 12'(refInternal));
   endtask

   // Track must be back before the next strobe, since the result is only read after busy ends.
   task automatic convert(input logic [1:0] ch, input acs_power_e pw);
      logic [ACS_DATA_W-1:0] want;
      want       = sarResult + 12'h135;
      sarResult  = want;
      cmdConvert = 1'b1;
      @(negedge clk);
      cmdConvert = 1'b0;
      repeat (4) @(negedge clk);
      chk("track", 12'h001, 12'(trackMode));
      chk("power up", 12'(PWR_NORMAL), 12'(powerState));
      for (k = 0; k < 100 && u_acs_if.busy !== 1'b1; k++)
         @(negedge clk);
      if (u_acs_if.busy !== 1'b1)
         give_up("busy");
      chk("hold", 12'h000, 12'(trackMode));
      chk("channel", 12'(ch), 12'(convChannel));
      for (k = 0; k < 200 && resultValid !== 1'b1; k++)
         @(negedge clk);
      if (resultValid !== 1'b1)
         give_up("resultValid");
      chk("result", want, resultData);
      chk("power", 12'(pw), 12'(powerState));
      if (pw == PWR_NORMAL)
         chk("track back", 12'h001, 12'(trackMode));
   endtask

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial
   begin
      n_errors   = 0;
      tests_run  = 0;
      reset      = 1'b1;
      cmdWrite   = 1'b0;
      cmdConvert = 1'b0;
      cmdWord    = 12'h000;
      sarResult  = 12'h5A3;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      chk("track at reset", 12'h000, 12'(trackMode));
      write_ctrl(2'h0, 1'b1, 2'h0, 2'h2);
      convert(2'h2, PWR_NORMAL);
      convert(2'h2, PWR_NORMAL);
      write_ctrl(2'h0, 1'b0, SEQ_CONSEC, 2'h2);
      for (int i = 0; i < 7; i++)
         convert(2'(i % 3), PWR_NORMAL);
      write_ctrl(2'h0, 1'b0, SEQ_CONSEC, 2'h1);
      for (int i = 0; i < 3; i++)
         convert(2'(i % 2), PWR_NORMAL);
      write_ctrl(PM_SHUTDOWN, 1'b1, 2'h0, 2'h3);
      convert(2'h3, PWR_SHUTDOWN);
      convert(2'h3, PWR_SHUTDOWN);
      write_ctrl(PM_STANDBY, 1'b0, 2'h1, 2'h1);
      convert(2'h1, PWR_STANDBY);
      convert(2'h1, PWR_STANDBY);
      tally_and_finish();
   end
endmodule
